// >>> core/fcd_pkg.sv
`default_nettype none
package fcd_pkg;
  // Command codes and match masks
  localparam logic [7:0] OP_SENSE      = 8'h04;
  localparam logic [7:0] OP_SEEK       = 8'h0F;
  localparam logic [7:0] OP_RSEEK      = 8'h8F;
  localparam logic [7:0] OP_CONFIG     = 8'h13;
  localparam logic [7:0] OP_DUMP       = 8'h0E;
  localparam logic [7:0] OP_RDID       = 8'h0A;
  localparam logic [7:0] OP_PERP       = 8'h12;
  localparam logic [7:0] OP_LOCK       = 8'h14;
  localparam logic [7:0] MASK_FULL     = 8'hFF;
  localparam logic [7:0] MASK_NO_B6    = 8'hBF;
  localparam logic [7:0] MASK_NO_B7    = 8'h7F;
  // Bit positions in command, parameter and result bytes
  localparam int BIT_DENSITY  = 6;
  localparam int BIT_DIR      = 6;
  localparam int BIT_LOCK     = 7;
  localparam int BIT_LOCK_RES = 4;
  localparam int BIT_HEAD     = 2;
  localparam int BIT_ISEEK_EN = 6;
  localparam int BIT_FIFO_OFF = 5;
  localparam int BIT_POLL     = 4;
  localparam int BIT_OVERWRITE = 7;
  // Fixed result values
  localparam logic [7:0] STAT_INVALID  = 8'h80;
  localparam logic [3:0] RES_LEN_ONE   = 4'h1;
  localparam logic [3:0] RES_LEN_RDID  = 4'h7;
  localparam logic [3:0] RES_LEN_DUMP  = 4'hA;
  localparam int         DUMP_SHARED_POS = 6;
  // Reset values
  localparam logic       RST_ISEEK_EN  = 1'b0;
  localparam logic       RST_FIFO_OFF  = 1'b1;
  localparam logic       RST_POLL      = 1'b0;
  localparam logic [3:0] RST_THR       = 4'h0;
  localparam logic [7:0] RST_PRECOMP   = 8'h00;
  localparam logic [7:0] RST_CYL       = 8'h00;

  typedef enum logic [5:0] {
    ST_IDLE     = 6'b00_0001,
    ST_PARAM    = 6'b00_0010,
    ST_DISPATCH = 6'b00_0100,
    ST_WSEEK    = 6'b00_1000,
    ST_WRDID    = 6'b01_0000,
    ST_RESULT   = 6'b10_0000
  } fcd_fsm_e;

  typedef struct packed {
    logic       implied_seek_enable;
    logic       fifo_off_bit;
    logic       poll_off;
    logic [3:0] fifo_threshold;
    logic [7:0] precomp_start_track;
  } fcd_cfg_s;

  typedef struct packed {
    logic [3:0] drive_bits;
    logic       gap;
    logic       write_gate_preerase;
  } fcd_perp_s;

  typedef struct packed {
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size_code;
  } fcd_id_s;

  typedef struct packed {
    logic [1:0] drive;
    logic       head;
    logic [7:0] cyl;
  } fcd_seek_s;

  typedef struct packed {
    logic [3:0] step_rate_time;
    logic [3:0] head_unload_time;
    logic [6:0] head_load_time;
    logic       non_dma_flag;
  } fcd_spec_s;
endpackage
`default_nettype wire

// >>> core/fcd_floppy_cmd_phase_decoder.sv
`default_nettype none
// Functional notes
// - Drive status query takes head/drive byte, returns one status byte of that drive.
// - Seek takes drive byte and target cylinder, moves head, returns no result.
// - Read identifier passes density flag, captures first good identifier on cylinder.
// - Read identifier returns status zero, one, two, then cylinder, head, sector, size.
// - Invalid code does nothing, enters standby, returns single byte 80H.
// - Register dump returns sector count after format, final sector after read/write.
// - Perpendicular drive bits are internal only, never touch drive select outputs.
// - With implied seek enabled, seek automatically before data transfer to another cylinder, host unaware.
module fcd_floppy_cmd_phase_decoder
  import fcd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Command and parameter bytes from the data FIFO
  input  wire logic [7:0]  cmd_byte,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  // Result bytes to the data FIFO
  output logic [7:0]       res_byte,
  output logic             res_valid,
  input  wire logic        res_ready,
  // Drive side: seek
  output logic             seek_req,
  output fcd_seek_s        seek_cmd,
  input  wire logic        seek_done,
  // Drive side: read identifier
  output logic             rdid_req,
  output logic             rdid_density,
  output fcd_seek_s        rdid_sel,
  input  wire logic        rdid_done,
  input  wire logic [7:0]  rdid_status_zero,
  input  wire logic [7:0]  rdid_status_one,
  input  wire logic [7:0]  rdid_status_two,
  input  wire fcd_id_s     rdid_id,
  // Drive status per drive
  input  wire logic [3:0][7:0] drive_status,
  // Data transfer hand-off
  input  wire logic        xfer_req,
  input  wire logic [1:0]  xfer_drive,
  input  wire logic [7:0]  xfer_cyl,
  output logic             xfer_ready,
  output logic             xfer_go,
  // State shared with other command logic
  input  wire fcd_spec_s   spec,
  input  wire logic        last_cmd_format,
  input  wire logic [7:0]  sectors_per_track_count,
  input  wire logic [7:0]  final_sector_number,
  output fcd_cfg_s         cfg,
  output fcd_perp_s        perp_cfg,
  output logic             cfg_lock,
  output logic             standby
);

  typedef struct packed {
    fcd_fsm_e        fsm;
    logic [7:0]      op;
    logic [1:0]      cnt;
    logic [2:0][7:0] prm;
    logic [9:0][7:0] res;
    logic [3:0]      res_len;
    logic [3:0]      res_idx;
    fcd_cfg_s        cfg;
    fcd_perp_s       perp;
    logic            lock;
    logic            standby;
    logic [3:0][7:0] present_cylinder;
    logic            seek_req;
    fcd_seek_s       seek;
    logic            implied;
    logic            rdid_req;
    logic            density;
    logic            xfer_go;
  } fcd_state_s;

  fcd_state_s q, d;

  function automatic logic is_op(input logic [7:0] op, input logic [7:0] code,
                                 input logic [7:0] mask);
    is_op = (op & mask) == code;
  endfunction

  function automatic logic [1:0] param_count(input logic [7:0] op);
    if (is_op(op, OP_CONFIG, MASK_FULL))
      param_count = 2'd3;
    else if (is_op(op, OP_SEEK, MASK_FULL) || is_op(op, OP_RSEEK, MASK_NO_B6))
      param_count = 2'd2;
    else if (is_op(op, OP_SENSE, MASK_FULL) || is_op(op, OP_RDID, MASK_NO_B6) ||
             is_op(op, OP_PERP, MASK_FULL))
      param_count = 2'd1;
    else
      param_count = 2'd0;
  endfunction

  always_comb begin
    d          = q;
    d.seek_req = 1'b0;
    d.rdid_req = 1'b0;
    d.xfer_go  = 1'b0;
    case (q.fsm)
      ST_IDLE: begin
        if (cmd_valid) begin
          d.op      = cmd_byte;
          d.cnt     = 2'd0;
          d.standby = 1'b0;
          d.fsm     = (param_count(cmd_byte) == 2'd0) ? ST_DISPATCH : ST_PARAM;
        end else if (xfer_req) begin
          // Seek is hidden from the host: only xfer_go is seen afterwards
          if (q.cfg.implied_seek_enable && xfer_cyl != q.present_cylinder[xfer_drive]) begin
            d.seek_req = 1'b1;
            d.seek     = '{drive: xfer_drive, head: 1'b0, cyl: xfer_cyl};
            d.implied  = 1'b1;
            d.fsm      = ST_WSEEK;
          end else begin
            d.xfer_go = 1'b1;
          end
        end
      end
      ST_PARAM: begin
        if (cmd_valid) begin
          d.prm[q.cnt] = cmd_byte;
          d.cnt        = q.cnt + 2'd1;
          if (q.cnt + 2'd1 == param_count(q.op))
            d.fsm = ST_DISPATCH;
        end
      end
      ST_DISPATCH: begin
        d.res_idx = 4'h0;
        d.res_len = RES_LEN_ONE;
        d.fsm     = ST_RESULT;
        if (is_op(q.op, OP_SENSE, MASK_FULL)) begin
          d.res[0] = {drive_status[q.prm[0][1:0]][7:3], q.prm[0][2:0]};
        end else if (is_op(q.op, OP_SEEK, MASK_FULL)) begin
          d.seek_req = 1'b1;
          d.seek     = '{drive: q.prm[0][1:0], head: q.prm[0][BIT_HEAD], cyl: q.prm[1]};
          d.implied  = 1'b0;
          d.fsm      = ST_WSEEK;
        end else if (is_op(q.op, OP_RSEEK, MASK_NO_B6)) begin
          d.seek_req = 1'b1;
          d.seek.drive = q.prm[0][1:0];
          d.seek.head  = q.prm[0][BIT_HEAD];
          // Relative count wraps modulo 256; no clamping at track 0
          d.seek.cyl   = q.op[BIT_DIR] ? q.present_cylinder[q.prm[0][1:0]] + q.prm[1]
                                       : q.present_cylinder[q.prm[0][1:0]] - q.prm[1];
          d.implied  = 1'b0;
          d.fsm      = ST_WSEEK;
        end else if (is_op(q.op, OP_CONFIG, MASK_FULL)) begin
          d.cfg.implied_seek_enable = q.prm[1][BIT_ISEEK_EN];
          d.cfg.fifo_off_bit        = q.prm[1][BIT_FIFO_OFF];
          d.cfg.poll_off            = q.prm[1][BIT_POLL];
          d.cfg.fifo_threshold      = q.prm[1][3:0];
          d.cfg.precomp_start_track = q.prm[2];
          d.fsm                     = ST_IDLE;
        end else if (is_op(q.op, OP_DUMP, MASK_FULL)) begin
          d.res[3:0] = {q.present_cylinder[3], q.present_cylinder[2],
                        q.present_cylinder[1], q.present_cylinder[0]};
          d.res[4]   = {spec.step_rate_time, spec.head_unload_time};
          d.res[5]   = {spec.head_load_time, spec.non_dma_flag};
          d.res[DUMP_SHARED_POS] = last_cmd_format ? sectors_per_track_count
                                               : final_sector_number;
          d.res[7]   = {q.lock, 1'b0, q.perp};
          d.res[8]   = {1'b0, q.cfg.implied_seek_enable, q.cfg.fifo_off_bit,
                        q.cfg.poll_off, q.cfg.fifo_threshold};
          d.res[9]   = q.cfg.precomp_start_track;
          d.res_len  = RES_LEN_DUMP;
        end else if (is_op(q.op, OP_RDID, MASK_NO_B6)) begin
          d.rdid_req   = 1'b1;
          d.density    = q.op[BIT_DENSITY];
          d.seek.drive = q.prm[0][1:0];
          d.seek.head  = q.prm[0][BIT_HEAD];
          d.fsm        = ST_WRDID;
        end else if (is_op(q.op, OP_PERP, MASK_FULL)) begin
          // Kept apart from the drive select outputs on purpose
          if (q.prm[0][BIT_OVERWRITE])
            d.perp.drive_bits = q.prm[0][5:2];
          d.perp.gap                 = q.prm[0][1];
          d.perp.write_gate_preerase = q.prm[0][0];
          d.fsm                      = ST_IDLE;
        end else if (is_op(q.op, OP_LOCK, MASK_NO_B7)) begin
          d.lock   = q.op[BIT_LOCK];
          d.res[0] = 8'h00;
          d.res[0][BIT_LOCK_RES] = q.op[BIT_LOCK];
        end else begin
          d.res[0]  = STAT_INVALID;
          d.standby = 1'b1;
        end
      end
      ST_WSEEK: begin
        if (seek_done) begin
          d.present_cylinder[q.seek.drive] = q.seek.cyl;
          d.xfer_go = q.implied;
          d.implied = 1'b0;
          d.fsm     = ST_IDLE;
        end
      end
      ST_WRDID: begin
        if (rdid_done) begin
          d.res[6:0] = {rdid_id.size_code, rdid_id.sector, rdid_id.head, rdid_id.cyl,
                        rdid_status_two, rdid_status_one, rdid_status_zero};
          d.res_len  = RES_LEN_RDID;
          d.res_idx  = 4'h0;
          d.fsm      = ST_RESULT;
        end
      end
      ST_RESULT: begin
        if (res_ready) begin
          d.res_idx = q.res_idx + 4'h1;
          if (q.res_idx + 4'h1 == q.res_len)
            d.fsm = ST_IDLE;
        end
      end
      default: d.fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.fsm <= ST_IDLE;
      q.cfg <= '{RST_ISEEK_EN, RST_FIFO_OFF, RST_POLL, RST_THR, RST_PRECOMP};
      q.present_cylinder <= {4{RST_CYL}};
    end else begin
      q <= d;
    end
  end

  assign cmd_ready    = (q.fsm == ST_IDLE) || (q.fsm == ST_PARAM);
  assign xfer_ready   = (q.fsm == ST_IDLE) && !cmd_valid;
  assign res_valid    = (q.fsm == ST_RESULT);
  assign res_byte     = (q.res_idx < RES_LEN_DUMP) ? q.res[q.res_idx] : 8'h00;
  assign seek_req     = q.seek_req;
  assign seek_cmd     = q.seek;
  assign rdid_req     = q.rdid_req;
  assign rdid_density = q.density;
  assign rdid_sel     = q.seek;
  assign xfer_go      = q.xfer_go;
  assign cfg          = q.cfg;
  assign perp_cfg     = q.perp;
  assign cfg_lock     = q.lock;
  assign standby      = q.standby;

  sequence s_dispatch(logic [7:0] code, logic [7:0] mask);
    q.fsm == ST_DISPATCH && is_op(q.op, code, mask);
  endsequence
  logic res_idx_is0;
  assign res_idx_is0 = (q.res_idx == 4'h0);
  sequence s_first_result(logic [7:0] val);
    res_valid && res_idx_is0 && res_byte == val;
  endsequence

  AST_SENSE_RES: assert property (@(posedge clk) disable iff (reset)
    s_dispatch(OP_SENSE, MASK_FULL) |=> s_first_result(
      {$past(drive_status[q.prm[0][1:0]][7:3]), $past(q.prm[0][2:0])}) ##0 q.res_len == 4'h1)
    else $error("drive status result wrong");
  AST_SEEK_NO_RES: assert property (@(posedge clk) disable iff (reset)
    (q.fsm == ST_WSEEK && seek_done && !q.implied) |=> q.fsm == ST_IDLE && !res_valid
      && q.present_cylinder[$past(q.seek.drive)] == $past(q.seek.cyl))
    else $error("seek end wrong");
  AST_SEEK_CYL: assert property (@(posedge clk) disable iff (reset)
    s_dispatch(OP_SEEK, MASK_FULL) |=> seek_req && seek_cmd.cyl == $past(q.prm[1]))
    else $error("seek target wrong");
  AST_RDID_DENS: assert property (@(posedge clk) disable iff (reset)
    s_dispatch(OP_RDID, MASK_NO_B6) |=> rdid_req && rdid_density == $past(q.op[BIT_DENSITY]))
    else $error("density flag wrong");
  AST_RDID_ORDER: assert property (@(posedge clk) disable iff (reset)
    (q.fsm == ST_WRDID && rdid_done) |=> s_first_result($past(rdid_status_zero))
      ##0 q.res[6] == $past(rdid_id.size_code) && q.res_len == 4'h7)
    else $error("read id result order wrong");
  AST_INVALID: assert property (@(posedge clk) disable iff (reset)
    (q.fsm == ST_DISPATCH && param_count(q.op) == 2'd0 && !is_op(q.op, OP_DUMP, MASK_FULL)
      && !is_op(q.op, OP_LOCK, MASK_NO_B7)) |=> s_first_result(8'h80) ##0 standby
      ##1 (!res_valid || res_byte == 8'h80))
    else $error("invalid code result wrong");
  AST_DUMP_SC: assert property (@(posedge clk) disable iff (reset)
    s_dispatch(OP_DUMP, MASK_FULL) |=> q.res[6] == ($past(last_cmd_format) ?
      $past(sectors_per_track_count) : $past(final_sector_number)))
    else $error("dump shared byte wrong");
  AST_PERP_ISOLATED: assert property (@(posedge clk) disable iff (reset)
    s_dispatch(OP_PERP, MASK_FULL) |=> $stable(seek_cmd) && !seek_req)
    else $error("perpendicular bits reached drive select");
  AST_ISEEK: assert property (@(posedge clk) disable iff (reset)
    (xfer_req && xfer_ready && q.cfg.implied_seek_enable
      && xfer_cyl != q.present_cylinder[xfer_drive]) |=> seek_req && !xfer_go
      && seek_cmd.cyl == $past(xfer_cyl))
    else $error("implied seek missing");
  AST_CFG_STORE: assert property (@(posedge clk) disable iff (reset)
    s_dispatch(OP_CONFIG, MASK_FULL) |=> cfg.fifo_threshold == $past(q.prm[1][3:0])
      && cfg.precomp_start_track == $past(q.prm[2]) && q.fsm == ST_IDLE)
    else $error("configure fields not stored");
  AST_LOCK_RES: assert property (@(posedge clk) disable iff (reset)
    s_dispatch(OP_LOCK, MASK_NO_B7) |=> s_first_result({3'b000, $past(q.op[7]), 4'h0})
      ##0 cfg_lock == $past(q.op[7]))
    else $error("lock result wrong");

endmodule
`default_nettype wire

// >>> test/fcd_drive_model.sv
`default_nettype none
module fcd_drive_model
  import fcd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Requests and answer delay
  input  wire logic        seek_req,
  input  wire logic        rdid_req,
  input  wire logic [3:0]  lat,
  // Status and identifier bytes to present
  input  wire logic [55:0] ans_in,
  // Answers
  output logic             seek_done,
  output logic             rdid_done,
  output logic [55:0]      ans
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic       act_q;
  logic       rd_q;
  logic [7:0] pat_q;
  always_ff @(posedge clk) begin
    pat_q     <= reset ? 8'h00 : pat_q + 8'h5B;
    seek_done <= 1'b0;
    rdid_done <= 1'b0;
    if (reset) begin
      act_q <= 1'b0;
    end else if (seek_req || rdid_req) begin
      act_q <= 1'b1;
      rd_q  <= rdid_req;
      cnt_q <= lat;
    end else if (act_q) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h0) begin
        act_q     <= 1'b0;
        seek_done <= !rd_q;
        rdid_done <= rd_q;
      end
    end
  end
  // Bytes churn outside the done cycle, so a late sample cannot match
  assign ans = rdid_done ? ans_in : {7{pat_q}};
endmodule
`default_nettype wire

// >>> test/floppy_cmd_phase_decoder_bench.sv
`default_nettype none
module floppy_cmd_phase_decoder_bench
  import fcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W_RDY = 0, W_RES = 1, W_SRQ = 2, W_SDN = 3, W_RID = 4, W_GO = 5, W_XR = 6;
  logic            clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, res_ready = 1'b0;
  logic            xfer_req = 1'b0, last_cmd_format = 1'b0, elock = 1'b0, h;
  logic [7:0]      cmd_byte = 8'h00, xfer_cyl = 8'h00, spc = 8'h00, c, t, b;
  logic [1:0]      xfer_drive = 2'h0, d;
  logic [3:0]      lat = 4'h0;
  logic [55:0]     ans_in = '0;
  logic [3:0][7:0] drive_status = '0;
  fcd_spec_s       spec = '0;
  fcd_cfg_s        ecfg = 15'h2000;
  fcd_perp_s       eperp = '0;
  fcd_seek_s       sv;
  logic [7:0]      cyl_exp [4] = '{default: 8'h00};
  logic [7:0]      bad [4] = '{8'h00, 8'h1F, 8'h3B, 8'hFF};
  int              err_count = 0, checks = 0;
  logic            cmd_ready, res_valid, seek_req, seek_done, rdid_req, rdid_done, xfer_go;
  logic            xfer_ready, rdid_density, cfg_lock, standby;
  logic [7:0]      res_byte;
  logic [55:0]     ans;
  fcd_seek_s       seek_cmd, rdid_sel;
  fcd_cfg_s        cfg;
  fcd_perp_s       perp_cfg;
  wire logic [6:0] evs = {xfer_ready, xfer_go, rdid_req, seek_done, seek_req, res_valid, cmd_ready};

  fcd_floppy_cmd_phase_decoder i_dut (
    .clk(clk), .reset(reset), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .res_byte(res_byte), .res_valid(res_valid), .res_ready(res_ready),
    .seek_req(seek_req), .seek_cmd(seek_cmd), .seek_done(seek_done), .rdid_req(rdid_req),
    .rdid_density(rdid_density), .rdid_sel(rdid_sel), .rdid_done(rdid_done),
    .rdid_status_zero(ans[55:48]), .rdid_status_one(ans[47:40]),
    .rdid_status_two(ans[39:32]), .rdid_id(ans[31:0]), .drive_status(drive_status),
    .xfer_req(xfer_req), .xfer_drive(xfer_drive), .xfer_cyl(xfer_cyl),
    .xfer_ready(xfer_ready), .xfer_go(xfer_go), .spec(spec),
    .last_cmd_format(last_cmd_format), .sectors_per_track_count(spc),
    .final_sector_number(~spc), .cfg(cfg), .perp_cfg(perp_cfg), .cfg_lock(cfg_lock),
    .standby(standby));
  fcd_drive_model i_drive (
    .clk(clk), .reset(reset), .seek_req(seek_req), .rdid_req(rdid_req), .lat(lat),
    .ans_in(ans_in), .seek_done(seek_done), .rdid_done(rdid_done), .ans(ans));

  always #2 clk = ~clk;

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  // Polled at falling edges, where outputs have settled
  task automatic wait_hi(input int s);
    int n;
    n = 0;
    while (evs[s] !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 300) begin
        err_count++;
        final_report();
      end
    end
  endtask

  task automatic cmd(input logic [7:0] q[$]);
    foreach (q[i]) begin
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_byte = q[i];
      wait_hi(W_RDY);
      @(posedge clk);
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_byte = ~cmd_byte;
  endtask

  // A stalled cycle after each byte checks that the result byte stands
  task automatic get(input logic [7:0] e);
    wait_hi(W_RES);
    chk(16'(res_byte), 16'(e));
    res_ready = 1'b1;
    @(posedge clk);
    @(negedge clk);
    res_ready = 1'b0;
    @(negedge clk);
  endtask

  task automatic dump(input logic lf);
    logic [7:0] e [10];
    spec = 16'($urandom);
    last_cmd_format = lf;
    spc = 8'($urandom);
    e = '{cyl_exp[0], cyl_exp[1], cyl_exp[2], cyl_exp[3], 8'(spec[15:8]), 8'(spec[7:0]),
          lf ? spc : ~spc, {elock, 1'b0, eperp}, {1'b0, ecfg[14:8]}, ecfg[7:0]};
    cmd('{OP_DUMP});
    foreach (e[i]) get(e[i]);
  endtask

  task automatic xfer(input logic [1:0] xd, input logic [7:0] xc);
    int n;
    int ns;
    n = 0;
    ns = 0;
    @(negedge clk);
    xfer_req = 1'b1;
    xfer_drive = xd;
    xfer_cyl = xc;
    wait_hi(W_XR);
    @(posedge clk);
    @(negedge clk);
    xfer_req = 1'b0;
    while (evs[W_GO] !== 1'b1) begin
      if (seek_req === 1'b1) begin
        ns++;
        chk(16'(seek_cmd), 16'({xd, 1'b0, xc}));
      end
      @(negedge clk);
      n++;
      if (n > 300) begin
        err_count++;
        final_report();
      end
    end
    chk(16'(ns), 16'(ecfg.implied_seek_enable && xc != cyl_exp[xd]));
    if (ns > 0) cyl_exp[xd] = xc;
  endtask

  initial begin
    void'($urandom(474));
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk(16'(cfg), 16'(ecfg));
    chk(16'({cfg_lock, standby, perp_cfg}), 16'h0000);
    for (int k = 0; k < 2; k++) begin
      ecfg = 15'($urandom);
      if (k == 1) ecfg.implied_seek_enable = 1'b1;
      cmd('{OP_CONFIG, 8'h00, {1'b0, ecfg[14:8]}, ecfg.precomp_start_track});
      repeat (3) @(negedge clk);
      chk(16'(cfg), 16'(ecfg));
      d = 2'($urandom);
      xfer(d, cyl_exp[d]);
      xfer(d, 8'(cyl_exp[d] + 8'h01));
    end
    // Last two relative seeks are pushed across the 0/255 wrap
    for (int k = 0; k < 6; k++) begin
      d = 2'($urandom);
      h = 1'($urandom);
      lat = 4'($urandom);
      c = k == 4 ? 8'(cyl_exp[d] + 8'h01) : (k == 5 ? 8'hFF : 8'($urandom));
      t = k < 3 ? c : (k[0] ? 8'(cyl_exp[d] + c) : 8'(cyl_exp[d] - c));
      cmd('{k < 3 ? OP_SEEK : (k[0] ? 8'hCF : OP_RSEEK), {5'h00, h, d}, c});
      wait_hi(W_SRQ);
      chk(16'(seek_cmd), 16'({d, h, t}));
      cyl_exp[d] = t;
      wait_hi(W_SDN);
      repeat (2) @(negedge clk);
      chk(16'({res_valid, cmd_ready}), 16'h0001);
    end
    for (int k = 0; k < 2; k++) begin
      b = 8'($urandom) & 8'hBF;
      b[7] = (k == 0);
      b[5:2] = 4'h1 << seek_cmd.drive;
      if (b[7]) eperp.drive_bits = b[5:2];
      eperp[1:0] = b[1:0];
      sv = seek_cmd;
      cmd('{OP_PERP, b});
      repeat (3) @(negedge clk);
      chk(16'(perp_cfg), 16'(eperp));
      chk(16'(seek_cmd), 16'(sv));
    end
    for (int k = 0; k < 2; k++) begin
      d = 2'($urandom);
      h = 1'($urandom);
      lat = 4'($urandom);
      ans_in = 56'({$urandom, $urandom});
      cmd('{k == 1 ? 8'h4A : OP_RDID, {5'h00, h, d}});
      wait_hi(W_RID);
      chk(16'({rdid_density, rdid_sel.drive, rdid_sel.head}), 16'({k[0], d, h}));
      for (int i = 6; i >= 0; i--) get(ans_in[8*i +: 8]);
    end
    foreach (bad[i]) begin
      cmd('{bad[i]});
      get(STAT_INVALID);
      chk(16'(standby), 16'h0001);
    end
    for (int k = 0; k < 4; k++) begin
      drive_status = 32'($urandom);
      h = 1'($urandom);
      cmd('{OP_SENSE, {5'h00, h, 2'(k)}});
      get({drive_status[k][7:3], h, 2'(k)});
      chk(16'(standby), 16'h0000);
    end
    for (int k = 0; k < 2; k++) begin
      b = k == 0 ? 8'h94 : OP_LOCK;
      cmd('{b});
      get({3'h0, b[7], 4'h0});
      elock = b[7];
      chk(16'(cfg_lock), 16'(elock));
      dump(k == 0);
    end
    final_report();
  end
endmodule
`default_nettype wire
